//--- include/stdc_pkg.sv
/*
  Shared constants and types for the signalling traffic diversion controller.
  Assumes a single 200 MHz core clock; all protocol timers count a 1 ms tick.
*/
package stdc_pkg;

  // Clock and timer base
  localparam int CLK_MHZ = 200;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int TICKS_W = 16;

  // Protocol times in milliseconds, each one second
  localparam int DIVERSION_HOLD_MS = 1000;
  localparam int FIRST_ACK_MS = 1000;
  localparam int SECOND_ACK_MS = 1000;
  localparam int REROUTING_HOLD_MS = 1000;

  // Same times as tick counts
  localparam logic [TICKS_W-1:0] DIVERSION_HOLD_TICKS = TICKS_W'(DIVERSION_HOLD_MS * 1000 / TICK_US);
  localparam logic [TICKS_W-1:0] FIRST_ACK_TICKS = TICKS_W'(FIRST_ACK_MS * 1000 / TICK_US);
  localparam logic [TICKS_W-1:0] SECOND_ACK_TICKS = TICKS_W'(SECOND_ACK_MS * 1000 / TICK_US);
  localparam logic [TICKS_W-1:0] REROUTING_HOLD_TICKS = TICKS_W'(REROUTING_HOLD_MS * 1000 / TICK_US);

  // Defaults of structure and values after reset
  localparam int MSG_W = 32;
  localparam int BUF_DEPTH = 16;
  localparam int CODE_W = 4;
  localparam logic [CODE_W-1:0] CODE_RST = 4'h0;
  localparam logic PATH_NORMAL = 1'b0;
  localparam logic PATH_ALT = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CB_HOLD,
    ST_CB_WAIT1,
    ST_CB_WAIT2,
    ST_FR_SEEK,
    ST_BLOCKED,
    ST_CR_HOLD,
    ST_DRAIN
  } stdc_state_t;

endpackage

//--- design/stdc_timer.sv
/*
  Prescaled one-shot protocol timer.
  Assumes start is a one-cycle pulse; a new start restarts the count.
*/
`timescale 1ns/1ps
`default_nettype none

module stdc_timer #(
  parameter int TICK_CYC = stdc_pkg::TICK_CYC,
  parameter int TICKS_W = stdc_pkg::TICKS_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control
  input wire logic start,
  input wire logic [TICKS_W-1:0] ticks,
  // Result
  output logic expire
);

  localparam int PRE_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

  if (TICK_CYC < 1 || TICKS_W < 1) begin : g_chk
    $error("stdc_timer: tick period and count width must be positive");
  end

  logic [PRE_W-1:0] pre, next_pre;
  logic [TICKS_W-1:0] remain, next_remain;
  logic active, next_active, next_expire;

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler restarts with the timer so every period is exact
  always_comb begin
    next_pre = pre;
    next_remain = remain;
    next_active = active;
    next_expire = 1'b0;
    if (start) begin
      next_pre = '0;
      next_remain = ticks;
      next_active = (ticks != '0);
      next_expire = (ticks == '0);
    end else if (active) begin
      if (pre == PRE_W'(TICK_CYC - 1)) begin
        next_pre = '0;
        next_remain = remain - 1'b1;
        if (remain == TICKS_W'(1)) begin
          next_active = 1'b0;
          next_expire = 1'b1;
        end
      end else begin
        next_pre = pre + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre <= '0;
      remain <= '0;
      active <= 1'b0;
      expire <= 1'b0;
    end else begin
      pre <= next_pre;
      remain <= next_remain;
      active <= next_active;
      expire <= next_expire;
    end
  end

endmodule

`default_nettype wire

//--- design/stdc_fifo.sv
/*
  Order-preserving diversion buffer.
  Assumes the writer honours inReady and the reader honours outValid.
*/
`timescale 1ns/1ps
`default_nettype none

module stdc_fifo #(
  parameter int WIDTH = stdc_pkg::MSG_W,
  parameter int DEPTH = stdc_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] count
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("stdc_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
  logic [CNT_W-1:0] next_count;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////////////
  // First in, first out: messages leave in arrival order
  always_comb begin
    inReady = (count != CNT_W'(DEPTH));
    outValid = (count != '0);
    outData = mem[rdPtr];
    push = inValid && inReady;
    pop = outReady && outValid;
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
    next_count = count + CNT_W'(push) - CNT_W'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

endmodule

`default_nettype wire

//--- design/stdc_diversion_ctrl.sv
/*
  Traffic diversion controller for one affected traffic flow of a signalling point:
  time-controlled and acknowledged changeback, forced and controlled rerouting.
  Assumes event inputs are one-cycle pulses synchronous to core_clk, and that the
  outgoing link accepts one message per cycle.
*/
// Functional notes
// - Unreachable far end uses time-controlled changeback.
// - Hold diverted traffic one second, then reopen.
// - Unanswered declaration completes through acknowledgement timeouts.
// - Transfer-prohibited ignored during running changeback.
// - Unexpected changeback acknowledgement is ignored.
// - Late declaration answered with acknowledgement only.
// - First timeout resends declaration, starts second timer.
// - Second timeout alerts maintenance, starts traffic.
// - Acknowledgement code selects the declaration it answers.
// - Transfer-prohibited starts forced rerouting.
// - Stop affected traffic, queue in buffer.
// - Restart on alternative route, buffer first.
// - Send transfer-prohibited to neighbours when required.
// - No traffic: find route, maybe transfer-prohibited.
// - No alternative route: destination inaccessible.
// - Transfer-allowed starts controlled rerouting.
// - Stop, queue, start one-second rerouting hold.
// - Send prohibited on new, allowed on alternative.
// - Hold expiry restarts on new route, buffer first.
// - No traffic: just note route usable.
// - Inaccessible destination becomes accessible again.
// - Unblock, resume users, perform transfer-allowed at once.
// - Acknowledgement returns the declaration's own code.
`timescale 1ns/1ps
`default_nettype none

module stdc_diversion_ctrl #(
  parameter int MSG_W = stdc_pkg::MSG_W,
  parameter int BUF_DEPTH = stdc_pkg::BUF_DEPTH,
  parameter int CODE_W = stdc_pkg::CODE_W,
  parameter int TICK_CYC = stdc_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Network status
  input wire logic linkRestored,
  input wire logic farEndReachable,
  input wire logic trafficDiverted,
  input wire logic tfpNeeded,
  // Received network management
  input wire logic tfpRx,
  input wire logic tfaRx,
  input wire logic cbDeclRx,
  input wire logic [CODE_W-1:0] cbDeclRxCode,
  input wire logic cbAckRx,
  input wire logic [CODE_W-1:0] cbAckRxCode,
  // Route determination
  input wire logic altRouteFound,
  input wire logic altRouteNone,
  // Traffic in
  input wire logic msgValid,
  output logic msgReady,
  input wire logic [MSG_W-1:0] msgData,
  // Traffic out
  output logic txValid,
  output logic [MSG_W-1:0] txData,
  output logic txAlt,
  // Sent network management
  output logic cbDeclTx,
  output logic [CODE_W-1:0] cbDeclCode,
  output logic cbAckTx,
  output logic [CODE_W-1:0] cbAckCode,
  output logic tfpTx,
  output logic tfaTx,
  // Status toward maintenance and user parts
  output logic maintAlert,
  output logic destAccessible,
  output logic userResume,
  output logic routeUsable
);

  localparam int CNT_W = $clog2(BUF_DEPTH + 1);

  if (CODE_W < 1 || MSG_W < 1) begin : g_chk
    $error("stdc_diversion_ctrl: code and message widths must be positive");
  end

  function automatic logic holding(input stdc_pkg::stdc_state_t s);
    holding = (s != stdc_pkg::ST_IDLE) && (s != stdc_pkg::ST_DRAIN);
  endfunction

  stdc_pkg::stdc_state_t state, next_state;
  logic next_txAlt, next_destAccessible;
  logic next_cbDeclTx, next_cbAckTx, next_tfpTx, next_tfaTx;
  logic next_maintAlert, next_userResume, next_routeUsable;
  logic [CODE_W-1:0] next_cbDeclCode, next_cbAckCode;
  logic tmrStart, tmrExpire;
  logic [stdc_pkg::TICKS_W-1:0] tmrTicks;

  logic next_msgReady, next_txValid;
  logic [MSG_W-1:0] next_txData;
  logic accepted, push, pop, fifoInReady, fifoOutValid;
  logic [MSG_W-1:0] fifoData;
  logic [CNT_W-1:0] fifoCount, countNext;

  ////////////////////////////////////////////////////////////////////////////////
  // One timer serves changeback and controlled rerouting; only one procedure runs at a time

  stdc_timer #(
    .TICK_CYC(TICK_CYC),
    .TICKS_W(stdc_pkg::TICKS_W)
  ) u_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(tmrStart),
    .ticks(tmrTicks),
    .expire(tmrExpire)
  );

  stdc_fifo #(
    .WIDTH(MSG_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .rstn(rstn),
    .inValid(push),
    .inReady(fifoInReady),
    .inData(msgData),
    .outValid(fifoOutValid),
    .outReady(pop),
    .outData(fifoData),
    .count(fifoCount)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Procedure sequencing

  always_comb begin
    next_state = state;
    next_txAlt = txAlt;
    next_destAccessible = destAccessible;
    next_cbDeclTx = 1'b0;
    next_cbDeclCode = cbDeclCode;
    next_tfpTx = 1'b0;
    next_tfaTx = 1'b0;
    next_maintAlert = 1'b0;
    next_userResume = 1'b0;
    next_routeUsable = 1'b0;
    tmrStart = 1'b0;
    tmrTicks = '0;
    // Answered in any state, echoing the received code
    next_cbAckTx = cbDeclRx;
    next_cbAckCode = cbDeclRx ? cbDeclRxCode : cbAckCode;
    unique case (state)
      stdc_pkg::ST_IDLE: begin
        // Acknowledgements without a pending declaration fall through here
        if (linkRestored && trafficDiverted) begin
          tmrStart = 1'b1;
          if (!farEndReachable) begin
            tmrTicks = stdc_pkg::DIVERSION_HOLD_TICKS;
            next_state = stdc_pkg::ST_CB_HOLD;
          end else begin
            // A fresh code per changeback tells answers apart; the resent declaration keeps it
            next_cbDeclCode = cbDeclCode + 1'b1;
            next_cbDeclTx = 1'b1;
            tmrTicks = stdc_pkg::FIRST_ACK_TICKS;
            next_state = stdc_pkg::ST_CB_WAIT1;
          end
        end else if (tfpRx) begin
          next_tfpTx = tfpNeeded;
          next_state = stdc_pkg::ST_FR_SEEK;
        end else if (tfaRx) begin
          if (trafficDiverted && txAlt == stdc_pkg::PATH_ALT) begin
            tmrStart = 1'b1;
            tmrTicks = stdc_pkg::REROUTING_HOLD_TICKS;
            next_tfpTx = 1'b1;
            next_tfaTx = 1'b1;
            next_state = stdc_pkg::ST_CR_HOLD;
          end else begin
            next_txAlt = stdc_pkg::PATH_NORMAL;
            next_routeUsable = 1'b1;
          end
        end
      end
      stdc_pkg::ST_CB_HOLD: begin
        // Transfer-prohibited is not looked at while changeback runs
        if (tmrExpire) begin
          next_txAlt = stdc_pkg::PATH_NORMAL;
          next_state = stdc_pkg::ST_DRAIN;
        end
      end
      stdc_pkg::ST_CB_WAIT1: begin
        if (cbAckRx && cbAckRxCode == cbDeclCode) begin
          next_txAlt = stdc_pkg::PATH_NORMAL;
          next_state = stdc_pkg::ST_DRAIN;
        end else if (tmrExpire) begin
          next_cbDeclTx = 1'b1;
          tmrStart = 1'b1;
          tmrTicks = stdc_pkg::SECOND_ACK_TICKS;
          next_state = stdc_pkg::ST_CB_WAIT2;
        end
      end
      stdc_pkg::ST_CB_WAIT2: begin
        if (cbAckRx && cbAckRxCode == cbDeclCode) begin
          next_txAlt = stdc_pkg::PATH_NORMAL;
          next_state = stdc_pkg::ST_DRAIN;
        end else if (tmrExpire) begin
          next_maintAlert = 1'b1;
          next_txAlt = stdc_pkg::PATH_NORMAL;
          next_state = stdc_pkg::ST_DRAIN;
        end
      end
      stdc_pkg::ST_FR_SEEK: begin
        if (altRouteFound) begin
          next_txAlt = stdc_pkg::PATH_ALT;
          next_state = stdc_pkg::ST_DRAIN;
        end else if (altRouteNone) begin
          next_destAccessible = 1'b0;
          next_state = stdc_pkg::ST_BLOCKED;
        end
      end
      stdc_pkg::ST_BLOCKED: begin
        // Queued traffic waits here until the route returns
        if (tfaRx) begin
          next_destAccessible = 1'b1;
          next_userResume = 1'b1;
          next_tfaTx = 1'b1;
          next_txAlt = stdc_pkg::PATH_NORMAL;
          next_state = stdc_pkg::ST_DRAIN;
        end
      end
      stdc_pkg::ST_CR_HOLD: begin
        if (tmrExpire) begin
          next_txAlt = stdc_pkg::PATH_NORMAL;
          next_state = stdc_pkg::ST_DRAIN;
        end
      end
      stdc_pkg::ST_DRAIN: begin
        if (countNext == '0) begin
          next_state = stdc_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= stdc_pkg::ST_IDLE;
      txAlt <= stdc_pkg::PATH_NORMAL;
      destAccessible <= 1'b1;
      cbDeclTx <= 1'b0;
      cbDeclCode <= stdc_pkg::CODE_RST;
      cbAckTx <= 1'b0;
      cbAckCode <= stdc_pkg::CODE_RST;
      tfpTx <= 1'b0;
      tfaTx <= 1'b0;
      maintAlert <= 1'b0;
      userResume <= 1'b0;
      routeUsable <= 1'b0;
    end else begin
      state <= next_state;
      txAlt <= next_txAlt;
      destAccessible <= next_destAccessible;
      cbDeclTx <= next_cbDeclTx;
      cbDeclCode <= next_cbDeclCode;
      cbAckTx <= next_cbAckTx;
      cbAckCode <= next_cbAckCode;
      tfpTx <= next_tfpTx;
      tfaTx <= next_tfaTx;
      maintAlert <= next_maintAlert;
      userResume <= next_userResume;
      routeUsable <= next_routeUsable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Traffic path: pass through, queue while stopped, drain queue first

  always_comb begin
    accepted = msgValid && msgReady;
    push = accepted && holding(state) && fifoInReady;
    pop = (state == stdc_pkg::ST_DRAIN) && fifoOutValid;
    countNext = fifoCount + CNT_W'(push) - CNT_W'(pop);
    next_txValid = pop || (accepted && state == stdc_pkg::ST_IDLE);
    next_txData = pop ? fifoData : msgData;
    // New traffic is held off until the queue is empty
    if (holding(next_state)) begin
      next_msgReady = (countNext < CNT_W'(BUF_DEPTH));
    end else begin
      next_msgReady = (next_state == stdc_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      msgReady <= 1'b0;
      txValid <= 1'b0;
      txData <= '0;
    end else begin
      msgReady <= next_msgReady;
      txValid <= next_txValid;
      txData <= next_txData;
    end
  end

endmodule

`default_nettype wire

//--- dv/stdc_remote_point.sv
/*
  Remote signalling point model that answers changeback declarations.
  Assumes the bench selects the answer mode and the answer delay.
*/
`timescale 1ns/1ps
`default_nettype none

module stdc_remote_point (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Behaviour: 0 silent, 1 correct code, 2 wrong code
  input wire logic [1:0] mode,
  input wire logic [11:0] ackDelay,
  // Declaration seen, answer sent
  input wire logic cbDeclTx,
  input wire logic [stdc_pkg::CODE_W-1:0] cbDeclCode,
  output logic cbAckRx,
  output logic [stdc_pkg::CODE_W-1:0] cbAckRxCode
);
  logic [stdc_pkg::CODE_W-1:0] held;
  int left;

  initial begin
    cbAckRx = 1'h0;
    cbAckRxCode = '0;
    held = '0;
    left = 0;
  end

  // Code line toggles outside the answer so a stale value never matches
  always @(negedge core_clk) begin
    cbAckRx <= 1'h0;
    cbAckRxCode <= ~cbAckRxCode;
    if (!rstn) begin
      left <= 0;
    end else if (cbDeclTx && mode != 2'h0) begin
      held <= cbDeclCode;
      left <= int'(ackDelay);
    end else if (left == 1) begin
      cbAckRx <= 1'h1;
      cbAckRxCode <= (mode == 2'h2) ? held + 1'h1 : held;
      left <= 0;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule
`default_nettype wire

//--- dv/stdc_diversion_ctrl_sva.sv
/*
  Port assertions for the diversion controller.
  Assumes TICK_CYC equals the instance value.
*/
`timescale 1ns/1ps
`default_nettype none

module stdc_diversion_ctrl_sva #(
  parameter int CODE_W = 4,
  parameter int TICK_CYC = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Inputs watched
  input wire logic tfpRx,
  input wire logic tfaRx,
  input wire logic cbDeclRx,
  input wire logic [CODE_W-1:0] cbDeclRxCode,
  input wire logic altRouteFound,
  input wire logic altRouteNone,
  // Outputs watched
  input wire logic txValid,
  input wire logic txAlt,
  input wire logic cbDeclTx,
  input wire logic [CODE_W-1:0] cbDeclCode,
  input wire logic cbAckTx,
  input wire logic [CODE_W-1:0] cbAckCode,
  input wire logic tfpTx,
  input wire logic tfaTx,
  input wire logic maintAlert,
  input wire logic destAccessible,
  input wire logic userResume,
  input wire logic routeUsable
);
  // Slack of a few cycles covers the timer start and output stages
  localparam int LO = TICK_CYC * 1000 - 4;
  localparam int HI = TICK_CYC * 1000 + 4;
  int sinceDecl;
  logic [CODE_W-1:0] lastCode;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sinceDecl <= 0;
      lastCode <= '0;
    end else begin
      if (cbDeclTx)
        sinceDecl <= 1;
      else if (sinceDecl < HI + 8)
        sinceDecl <= sinceDecl + 1;
      if (cbDeclTx)
        lastCode <= cbDeclCode;
    end
  end

  ////////////////////////////////////////
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_ack_echo: assert property (cbDeclRx |=> cbAckTx && cbAckCode == $past(cbDeclRxCode))
    else $error("declaration not answered with its code");
  a_decl_code: assert property (cbDeclTx |-> cbDeclCode == lastCode + 1'h1 ||
    (cbDeclCode == lastCode && sinceDecl >= LO && sinceDecl <= HI))
    else $error("declaration resent early or with new code");
  a_decl_pulse: assert property (cbDeclTx |=> !cbDeclTx [*8])
    else $error("declaration repeated too soon");
  a_alert_time: assert property (maintAlert |-> sinceDecl >= LO && sinceDecl <= HI && !txAlt)
    else $error("alert off the second timeout");
  a_dest_block: assert property ($fell(destAccessible) |-> $past(altRouteNone))
    else $error("destination blocked without cause");
  a_blocked_quiet: assert property (!destAccessible |-> !txValid)
    else $error("traffic sent to blocked destination");
  a_resume_set: assert property (userResume |-> destAccessible && tfaTx && $past(tfaRx))
    else $error("resume without access and allowed message");
  a_alt_cause: assert property ($rose(txAlt) |-> $past(altRouteFound))
    else $error("alternative path taken without route");
  a_cr_msgs: assert property (tfaTx && !userResume |-> tfpTx && $past(tfaRx))
    else $error("controlled reroute messages not paired");
  a_usable: assert property (routeUsable |-> $past(tfaRx) && !txAlt && !tfaTx)
    else $error("route usable note with actions");
  a_tfp_cause: assert property (tfpTx |-> $past(tfpRx) || $past(tfaRx))
    else $error("prohibited message without cause");

  c_alert: cover property (maintAlert);
  c_resume: cover property (userResume);
  c_usable: cover property (routeUsable);
  c_back: cover property ($fell(txAlt));
endmodule

bind stdc_diversion_ctrl stdc_diversion_ctrl_sva #(.CODE_W(CODE_W), .TICK_CYC(TICK_CYC)) chk_u (
  .core_clk, .rstn, .tfpRx, .tfaRx, .cbDeclRx, .cbDeclRxCode, .altRouteFound, .altRouteNone,
  .txValid, .txAlt, .cbDeclTx, .cbDeclCode, .cbAckTx, .cbAckCode, .tfpTx, .tfaTx,
  .maintAlert, .destAccessible, .userResume, .routeUsable
);
`default_nettype wire

//--- dv/stdc_diversion_ctrl_bench.sv
/*
  Directed bench for the diversion controller.
  Assumes the remote point model; timers shortened through TICK_CYC.
*/
`timescale 1ns/1ps
`default_nettype none

module stdc_diversion_ctrl_bench;
  localparam int TC = 2;
  localparam int HOLD = TC * 1000;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic linkRestored = 1'h0, farEndReachable = 1'h1, trafficDiverted = 1'h1, tfpNeeded = 1'h0;
  logic tfpRx = 1'h0, tfaRx = 1'h0, cbDeclRx = 1'h0, altRouteFound = 1'h0, altRouteNone = 1'h0;
  logic [3:0] cbDeclRxCode = 4'h0;
  logic msgValid = 1'h0;
  logic [31:0] msgData = 32'h0;
  logic [1:0] ackMode = 2'h0;
  logic [11:0] ackDelay = 12'h014;
  logic msgReady, txValid, txAlt, cbDeclTx, cbAckTx, tfpTx, tfaTx, maintAlert;
  logic destAccessible, userResume, routeUsable, cbAckRx;
  logic [31:0] txData;
  logic [3:0] cbDeclCode, cbAckCode, cbAckRxCode;
  logic [31:0] rxq[$], expq[$];
  int nDecl, nAlert, nTfp, nTfa, nRes, nUse, nAck, cyc, error_cnt, cmp_count, seq;

  always #2.5 core_clk = ~core_clk;

  stdc_diversion_ctrl #(.TICK_CYC(TC)) dut_u (
    .core_clk, .rstn, .linkRestored, .farEndReachable, .trafficDiverted, .tfpNeeded,
    .tfpRx, .tfaRx, .cbDeclRx, .cbDeclRxCode, .cbAckRx, .cbAckRxCode, .altRouteFound,
    .altRouteNone, .msgValid, .msgReady, .msgData, .txValid, .txData, .txAlt, .cbDeclTx,
    .cbDeclCode, .cbAckTx, .cbAckCode, .tfpTx, .tfaTx, .maintAlert, .destAccessible,
    .userResume, .routeUsable
  );

  stdc_remote_point peer_u (
    .core_clk, .rstn, .mode(ackMode), .ackDelay, .cbDeclTx, .cbDeclCode, .cbAckRx, .cbAckRxCode
  );

  ////////////////////////////////////////
  // Pulse outputs are counted so scenarios need not hit the exact cycle
  always @(posedge core_clk) begin
    cyc++;
    if (txValid)
      rxq.push_back(txData);
    nDecl += cbDeclTx;
    nAlert += maintAlert;
    nTfp += tfpTx;
    nTfa += tfaTx;
    nRes += userResume;
    nUse += routeUsable;
    nAck += cbAckTx;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("mismatches=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'h1;
    @(negedge core_clk);
    s = 1'h0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      seq++;
      msgValid = 1'h1;
      msgData = 32'h0a00 + seq;
      expq.push_back(msgData);
      do @(posedge core_clk); while (!msgReady);
    end
    @(negedge core_clk);
    msgValid = 1'h0;
  endtask

  // Puts the flow on the alternative path first, so a later return to normal is visible
  task automatic to_alt;
    pulse(tfpRx);
    pulse(altRouteFound);
    idle(2);
    check(txAlt, 1'h1);
  endtask

  // Waits for n messages, then compares order and path
  task automatic drain(input int n, input logic alt);
    int k;
    k = 0;
    while (rxq.size() < n && k < 2100) begin
      @(negedge core_clk);
      k++;
    end
    for (int i = 0; i < n; i++)
      check(rxq.pop_front(), expq.pop_front());
    check(txAlt, alt);
  endtask

  ////////////////////////////////////////
  task automatic t_declrx;
    int k;
    k = nAck;
    cbDeclRxCode = 4'h9;
    pulse(cbDeclRx);
    cbDeclRxCode = 4'h6;
    idle(2);
    check(nAck, k + 1);
    check(cbAckCode, 4'h9);
  endtask

  task automatic t_unreach;
    int d;
    d = nDecl;
    to_alt;
    farEndReachable = 1'h0;
    pulse(linkRestored);
    send(3);
    idle(HOLD - 20);
    check(rxq.size(), 0);
    check(nDecl, d);
    drain(3, 1'h0);
    farEndReachable = 1'h1;
  endtask

  task automatic t_acked(input logic [11:0] dly);
    int d;
    int a;
    d = nDecl;
    a = nAlert;
    to_alt;
    ackMode = 2'h1;
    ackDelay = dly;
    pulse(linkRestored);
    send(2);
    drain(2, 1'h0);
    check(nDecl, d + 1);
    check(nAlert, a);
  endtask

  // Answers carry a wrong code and a prohibited message arrives meanwhile
  task automatic t_unacked;
    int d;
    int p;
    d = nDecl;
    p = nTfp;
    to_alt;
    ackMode = 2'h2;
    pulse(linkRestored);
    send(2);
    pulse(tfpRx);
    idle(HOLD);
    check(nDecl, d + 2);
    check(rxq.size(), 0);
    idle(HOLD);
    check(nAlert, 1);
    check(nTfp, p);
    drain(2, 1'h0);
  endtask

  task automatic t_block;
    int p;
    to_alt;
    p = nTfp;
    tfpNeeded = 1'h1;
    pulse(tfpRx);
    send(2);
    pulse(altRouteNone);
    idle(20);
    check(destAccessible, 1'h0);
    check(rxq.size(), 0);
    check(nTfp, p + 1);
    pulse(tfaRx);
    drain(2, 1'h0);
    check(destAccessible, 1'h1);
    check(nRes, 1);
    tfpNeeded = 1'h0;
  endtask

  task automatic t_reroute;
    int p;
    int t;
    p = nTfp;
    pulse(tfpRx);
    send(2);
    check(rxq.size(), 0);
    pulse(altRouteFound);
    drain(2, 1'h1);
    check(nTfp, p);
    t = nTfa;
    pulse(tfaRx);
    send(2);
    idle(HOLD - 20);
    check(rxq.size(), 0);
    check(nTfp, p + 1);
    check(nTfa, t + 1);
    drain(2, 1'h0);
    pulse(tfaRx);
    idle(4);
    check(nUse, 1);
    check(nTfa, t + 1);
  endtask

  initial begin
    idle(16);
    rstn = 1'h1;
    idle(2);
    send(2);
    drain(2, 1'h0);
    t_declrx;
    t_unreach;
    t_acked(12'h014);
    t_acked(12'h5dc);
    t_unacked;
    t_block;
    t_reroute;
    print_verdict;
  end
endmodule
`default_nettype wire
